// >>> alu_status_pkg.sv
// Constants, types and register map for the status register bank
package alu_status_pkg;

  // Register fields of the status byte
  localparam int IND_BANK_BIT   = 7;
  localparam int DIR_BANK_HI    = 6;
  localparam int DIR_BANK_LO    = 5;
  localparam int TIMEOUT_BIT    = 4;
  localparam int POWERDOWN_BIT  = 3;
  localparam int ZERO_BIT       = 2;
  localparam int NIB_CARRY_BIT  = 1;
  localparam int CARRY_BIT      = 0;

  // Value after power-on reset: banks 0, both cause flags set
  localparam logic [7:0] STATUS_RESET = 8'h18;

  // Core file address of the status byte (both banks)
  localparam logic [6:0] STATUS_FILE_ADDR = 7'h03;

  // Register indices and APB byte addresses
  localparam logic [11:0] STATUS_IDX_LO    = 12'h003;
  localparam logic [11:0] STATUS_IDX_HI    = 12'h083;
  localparam logic [11:0] STATUS_ADDR_LO   = 12'h00C;
  localparam logic [11:0] STATUS_ADDR_HI   = 12'h20C;
  localparam logic [11:0] IRQ_STATUS_ADDR  = 12'h300;
  localparam logic [11:0] IRQ_MASK_ADDR    = 12'h304;

  // Interrupt status bits
  localparam int IRQ_TIMEOUT = 0;
  localparam int IRQ_SLEEP   = 1;
  localparam int IRQ_ZERO    = 2;
  localparam int IRQ_WIDTH   = 3;
  localparam logic [2:0] IRQ_RESET = 3'h0;

  // Operation classes presented by the execution unit
  typedef enum logic [3:0] {
    OP_ADD  = 4'h0,
    OP_SUB  = 4'h1,
    OP_AND  = 4'h2,
    OP_IOR  = 4'h3,
    OP_XOR  = 4'h4,
    OP_COM  = 4'h5,
    OP_INC  = 4'h6,
    OP_DEC  = 4'h7,
    OP_RRC  = 4'h8,
    OP_RLC  = 4'h9,
    OP_CLR  = 4'hA,
    OP_MOVZ = 4'hB,
    OP_MOVW = 4'hC,
    OP_SWAP = 4'hD,
    OP_BCLR = 4'hE,
    OP_BSET = 4'hF
  } op_e;

endpackage : alu_status_pkg

// >>> alu_link_if.sv
// Signals between the status bank and its flag arithmetic unit
`timescale 1ns/100ps
interface alu_link_if;
  import alu_status_pkg::*;
  op_e        op;
  logic [7:0] opa;
  logic [7:0] opb;
  logic [2:0] bit_sel;
  logic       carry_in;
  logic [7:0] result;
  logic       zero;
  logic       nib_carry;
  logic       carry;
  logic       upd_z;
  logic       upd_dc;
  logic       upd_c;

  modport bank (output op, opa, opb, bit_sel, carry_in,
                input  result, zero, nib_carry, carry,
                       upd_z, upd_dc, upd_c);
  modport unit (input  op, opa, opb, bit_sel, carry_in,
                output result, zero, nib_carry, carry,
                       upd_z, upd_dc, upd_c);
endinterface : alu_link_if

// >>> flag_alu.sv
// Arithmetic unit producing the result byte and the three flags
`timescale 1ns/100ps
module flag_alu (
  alu_link_if.unit lnk
);
  import alu_status_pkg::*;

  logic [8:0] sum;
  logic [4:0] nib;
  logic [7:0] addend;

  // Subtract adds the two's complement; flags then mean no borrow
  always_comb begin
    addend = (lnk.op == OP_SUB) ? ~lnk.opb : lnk.opb;
    sum    = {1'b0, lnk.opa} + {1'b0, addend}
           + {8'h00, lnk.op == OP_SUB};
    nib    = {1'b0, lnk.opa[3:0]} + {1'b0, addend[3:0]}
           + {4'h0, lnk.op == OP_SUB};
  end

  // Result and flag selection per operation class
  always_comb begin
    lnk.result    = lnk.opa;
    lnk.nib_carry = nib[4];
    lnk.carry     = sum[8];
    lnk.upd_z     = 1'b1;
    lnk.upd_dc    = 1'b0;
    lnk.upd_c     = 1'b0;
    case (lnk.op)
      OP_ADD, OP_SUB: begin
        lnk.result = sum[7:0];
        lnk.upd_dc = 1'b1;
        lnk.upd_c  = 1'b1;
      end
      OP_AND:  lnk.result = lnk.opa & lnk.opb;
      OP_IOR:  lnk.result = lnk.opa | lnk.opb;
      OP_XOR:  lnk.result = lnk.opa ^ lnk.opb;
      OP_COM:  lnk.result = ~lnk.opa;
      OP_INC:  lnk.result = lnk.opa + 8'h01;
      OP_DEC:  lnk.result = lnk.opa - 8'h01;
      OP_RRC: begin
        lnk.result = {lnk.carry_in, lnk.opa[7:1]};
        lnk.carry  = lnk.opa[0];
        lnk.upd_z  = 1'b0;
        lnk.upd_c  = 1'b1;
      end
      OP_RLC: begin
        lnk.result = {lnk.opa[6:0], lnk.carry_in};
        lnk.carry  = lnk.opa[7];
        lnk.upd_z  = 1'b0;
        lnk.upd_c  = 1'b1;
      end
      OP_CLR:  lnk.result = 8'h00;
      OP_MOVZ: lnk.result = lnk.opa;
      OP_MOVW: begin
        lnk.result = lnk.opb;
        lnk.upd_z  = 1'b0;
      end
      OP_SWAP: begin
        lnk.result = {lnk.opa[3:0], lnk.opa[7:4]};
        lnk.upd_z  = 1'b0;
      end
      OP_BCLR: begin
        lnk.result = lnk.opa & ~(8'h01 << lnk.bit_sel);
        lnk.upd_z  = 1'b0;
      end
      OP_BSET: begin
        lnk.result = lnk.opa | (8'h01 << lnk.bit_sel);
        lnk.upd_z  = 1'b0;
      end
      default: lnk.upd_z = 1'b0;
    endcase
    lnk.zero = (lnk.result == 8'h00);
  end

endmodule : flag_alu

// >>> alu_status_bank_select.sv
// Status register bank: ALU flags, reset causes, bank select, APB
// Function
// - Status reachable as ordinary file register at addresses 03h and 83h.
// - Flag-updating instruction to status suppresses data write to Z, DC, C.
// - Z on zero result, DC from bit 3 carry, C from bit 7 carry.
// - Cause flags not writable; set/cleared by watchdog, sleep, power-up.
// - Clear-register on status gives upper three zero, Z set, rest kept.
// - Two direct bank bits pick one of four 128-byte banks.
// - Top bit picks banks 2-3 for indirect access; keep unused bits clear.
// - In subtraction C and DC read as inverted borrow.
// - Subtraction adds the two's complement of the second operand.
// - Rotates through carry load C with the bit shifted out.
// - Power-on clears direct bank bits, sets both cause flags.
`timescale 1ns/100ps
module alu_status_bank_select (
  input  wire logic                  mclk_i,
  input  wire logic                  reset_i,
  // APB slave
  input  wire logic                  psel_i,
  input  wire logic                  penable_i,
  input  wire logic                  pwrite_i,
  input  wire logic [11:0]           paddr_i,
  input  wire logic [31:0]           pwdata_i,
  output logic      [31:0]           prdata_o,
  output logic                       pready_o,
  output logic                       pslverr_o,
  output logic                       irq_o,
  // Execution unit side
  input  wire logic                  exec_i,
  input  wire alu_status_pkg::op_e   op_i,
  input  wire logic [6:0]            file_addr_i,
  input  wire logic [7:0]            file_data_i,
  input  wire logic                  use_literal_i,
  input  wire logic [7:0]            literal_i,
  input  wire logic [7:0]            work_i,
  input  wire logic [2:0]            bit_sel_i,
  input  wire logic                  to_file_i,
  input  wire logic [7:0]            ind_ptr_i,
  // Watchdog and sleep events, one-cycle pulses
  input  wire logic                  wdt_clear_i,
  input  wire logic                  sleep_i,
  input  wire logic                  wdt_timeout_i,
  // Results
  output logic      [7:0]            status_o,
  output logic      [7:0]            result_o,
  output logic                       result_valid_o,
  output logic      [8:0]            direct_addr_o,
  output logic      [8:0]            indirect_addr_o
);
  import alu_status_pkg::*;

  // Whole module state in one record
  typedef struct packed {
    logic [7:0]           status;
    logic [7:0]           result;
    logic                 result_valid;
    logic [IRQ_WIDTH-1:0] irq_status;
    logic [IRQ_WIDTH-1:0] irq_mask;
    logic [31:0]          prdata;
  } state_s;

  state_s st;
  state_s next_st;

  alu_link_if lnk ();

  logic                 is_status;
  logic                 core_wr_status;
  logic                 apb_setup;
  logic                 apb_access;
  logic                 apb_wr;
  logic                 apb_hit;
  logic [31:0]          rd_mux;
  logic [IRQ_WIDTH-1:0] irq_set;
  logic [7:0]           wr_byte;

  flag_alu u_alu (
    .lnk (lnk.unit)
  );

  // Both mirrored file addresses decode to the status byte
  assign is_status = (file_addr_i == STATUS_FILE_ADDR);
  assign core_wr_status = exec_i & to_file_i & is_status;

  // Operand fetch: literal if selected, else status reads itself, else file
  assign lnk.op       = op_i;
  assign lnk.opa      = use_literal_i ? literal_i
                      : (is_status ? st.status : file_data_i);
  assign lnk.opb      = work_i;
  assign lnk.bit_sel  = bit_sel_i;
  assign lnk.carry_in = st.status[CARRY_BIT];

  // APB phase decode
  assign apb_setup  = psel_i & ~penable_i;
  assign apb_access = psel_i & penable_i;
  assign apb_hit    = (paddr_i == STATUS_ADDR_LO)
                    | (paddr_i == STATUS_ADDR_HI)
                    | (paddr_i == IRQ_STATUS_ADDR)
                    | (paddr_i == IRQ_MASK_ADDR);

  // A bus write waits while the core writes the status as a file register;
  // flag updates from other instructions are not held off, and a bus write of the status overrides them
  assign pready_o  = ~(apb_access & pwrite_i & core_wr_status);
  assign apb_wr    = apb_access & pwrite_i & pready_o;
  assign pslverr_o = apb_access & pready_o & ~apb_hit;
  assign wr_byte   = pwdata_i[7:0];

  // Next-state logic for the whole block
  always_comb begin
    next_st = st;
    irq_set = '0;

    // Read data multiplexer, unmapped reads return zero
    rd_mux = 32'h0000_0000;
    case (paddr_i)
      STATUS_ADDR_LO,
      STATUS_ADDR_HI:  rd_mux = {24'h00_0000, st.status};
      IRQ_STATUS_ADDR: rd_mux = {29'h0, st.irq_status};
      IRQ_MASK_ADDR:   rd_mux = {29'h0, st.irq_mask};
      default:         rd_mux = 32'h0000_0000;
    endcase

    // Read data captured in the setup phase, held through access
    if (apb_setup) begin
      next_st.prdata = rd_mux;
    end

    // Result register for the execution unit
    next_st.result_valid = exec_i;
    if (exec_i) begin
      next_st.result = lnk.result;
    end

    // Data write of the result into the status byte; cause flags are
    // never written by data, and a flag-affecting instruction loses
    // its data write to all three arithmetic flags, not only its own
    if (core_wr_status) begin
      next_st.status[7:5] = lnk.result[7:5];
      if (!(lnk.upd_z || lnk.upd_dc || lnk.upd_c)) begin
        next_st.status[2:0] = lnk.result[2:0];
      end
    end

    // Flag updates win over the data write of the same bits
    if (exec_i && lnk.upd_z) begin
      next_st.status[ZERO_BIT] = lnk.zero;
      irq_set[IRQ_ZERO] = lnk.zero;
    end
    if (exec_i && lnk.upd_dc) begin
      next_st.status[NIB_CARRY_BIT] = lnk.nib_carry;
    end
    if (exec_i && lnk.upd_c) begin
      next_st.status[CARRY_BIT] = lnk.carry;
    end

    // Bus write acts like a plain move: cause flags untouched
    if (apb_wr && (paddr_i == STATUS_ADDR_LO
                   || paddr_i == STATUS_ADDR_HI)) begin
      next_st.status[7:5] = wr_byte[7:5];
      next_st.status[2:0] = wr_byte[2:0];
    end

    // Watchdog clear and sleep raise the timeout flag
    if (wdt_clear_i) begin
      next_st.status[TIMEOUT_BIT]   = 1'b1;
      next_st.status[POWERDOWN_BIT] = 1'b1;
    end
    if (sleep_i) begin
      next_st.status[TIMEOUT_BIT]   = 1'b1;
      next_st.status[POWERDOWN_BIT] = 1'b0;
      irq_set[IRQ_SLEEP] = 1'b1;
    end
    // A time-out is the last word: it must survive a racing clear
    if (wdt_timeout_i) begin
      next_st.status[TIMEOUT_BIT] = 1'b0;
      irq_set[IRQ_TIMEOUT] = 1'b1;
    end

    // Interrupt mask write
    if (apb_wr && paddr_i == IRQ_MASK_ADDR) begin
      next_st.irq_mask = pwdata_i[IRQ_WIDTH-1:0];
    end

    // Write-one-to-clear, a new event in the same cycle wins
    if (apb_wr && paddr_i == IRQ_STATUS_ADDR) begin
      next_st.irq_status = st.irq_status
                         & ~pwdata_i[IRQ_WIDTH-1:0];
    end
    next_st.irq_status = next_st.irq_status | irq_set;
  end

  // State register; arithmetic flags given a defined zero
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      st.status       <= STATUS_RESET;
      st.result       <= 8'h00;
      st.result_valid <= 1'b0;
      st.irq_status   <= IRQ_RESET;
      st.irq_mask     <= IRQ_RESET;
      st.prdata       <= 32'h0000_0000;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state record
  assign status_o       = st.status;
  assign result_o       = st.result;
  assign result_valid_o = st.result_valid;
  assign prdata_o       = st.prdata;
  assign irq_o          = |(st.irq_status & st.irq_mask);

  // Direct address: bank bits above the 7-bit file address
  assign direct_addr_o = {st.status[DIR_BANK_HI],
                          st.status[DIR_BANK_LO],
                          file_addr_i};

  // Indirect address: one bank bit above the 8-bit pointer
  assign indirect_addr_o = {st.status[IND_BANK_BIT],
                            ind_ptr_i};

endmodule : alu_status_bank_select

// >>> alu_status_checker.sv
// Port-level checks for the status register bank
`timescale 1ns/100ps
module alu_status_checker
  import alu_status_pkg::*;
(
  input wire logic                mclk_i,
  input wire logic                reset_i,
  input wire logic                exec_i,
  input wire alu_status_pkg::op_e op_i,
  input wire logic [6:0]          file_addr_i,
  input wire logic                to_file_i,
  input wire logic [7:0]          ind_ptr_i,
  input wire logic                wdt_clear_i,
  input wire logic                sleep_i,
  input wire logic                wdt_timeout_i,
  input wire logic [7:0]          status_o,
  input wire logic [8:0]          direct_addr_o,
  input wire logic [8:0]          indirect_addr_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);
  // Any cause-flag event this cycle
  logic ev;
  assign ev = wdt_clear_i | sleep_i | wdt_timeout_i;
  // Clear aimed at the status byte; events excluded as they move bits 4:3
  sequence clr_hit;
    exec_i && op_i == OP_CLR && to_file_i && file_addr_i == 7'h03 && !ev;
  endsequence
  chk_reset_value: assert property ($fell(reset_i) |-> status_o[7:3] == 5'b00011)
    else $error("status not at power-on value");
  chk_dir_bank: assert property (direct_addr_o == {status_o[6:5], file_addr_i})
    else $error("direct address ignores bank bits");
  chk_ind_bank: assert property (indirect_addr_o == {status_o[7], ind_ptr_i})
    else $error("indirect address ignores bank bit");
  chk_cause_hold: assert property (!ev |=> $stable(status_o[4:3]))
    else $error("cause flags moved without event");
  chk_timeout_clear: assert property (wdt_timeout_i |=> !status_o[4])
    else $error("timeout flag not cleared");
  chk_sleep_flags: assert property (sleep_i && !wdt_timeout_i && !wdt_clear_i |=> status_o[4:3] == 2'b10)
    else $error("sleep did not set cause flags");
  chk_wdt_clear: assert property (wdt_clear_i && !sleep_i && !wdt_timeout_i |=> status_o[4:3] == 2'b11)
    else $error("watchdog clear did not set cause flags");
  chk_clr_status: assert property (clr_hit |=> status_o[7:5] == 3'b000 && status_o[2] && $stable(status_o[4:3])
    && $stable(status_o[1:0]))
    else $error("clear of status gave wrong byte");
endmodule : alu_status_checker

bind alu_status_bank_select alu_status_checker u_chk (.mclk_i(mclk_i), .reset_i(reset_i), .exec_i(exec_i),
  .op_i(op_i), .file_addr_i(file_addr_i), .to_file_i(to_file_i), .ind_ptr_i(ind_ptr_i),
  .wdt_clear_i(wdt_clear_i), .sleep_i(sleep_i), .wdt_timeout_i(wdt_timeout_i), .status_o(status_o),
  .direct_addr_o(direct_addr_o), .indirect_addr_o(indirect_addr_o));

// >>> exec_core_model.sv
// Behavioural execution unit feeding the bank's core side
`timescale 1ns/100ps
module exec_core_model
  import alu_status_pkg::*;
(
  input  wire logic          mclk_i,
  output logic               exec_o,
  output alu_status_pkg::op_e op_o,
  output logic [6:0]         file_addr_o,
  output logic [7:0]         file_data_o,
  output logic               use_literal_o,
  output logic [7:0]         literal_o,
  output logic [7:0]         work_o,
  output logic [2:0]         bit_sel_o,
  output logic               to_file_o,
  output logic [7:0]         ind_ptr_o
);
  // Idle values at time zero
  initial begin
    exec_o = 1'b0;
    op_o = OP_MOVW;
    {file_addr_o, file_data_o, use_literal_o, literal_o, work_o, bit_sel_o, to_file_o, ind_ptr_o} = '0;
  end
  // One instruction for one cycle; memory operand is junk when status is addressed
  task automatic issue(input op_e op, input logic [6:0] fa, input logic lit, input logic [7:0] a,
                       input logic [7:0] w, input logic [2:0] bs, input logic tf);
    @(posedge mclk_i);
    exec_o <= 1'b1;
    op_o <= op;
    file_addr_o <= fa;
    use_literal_o <= lit;
    literal_o <= a;
    file_data_o <= (fa == 7'h03) ? ~a : a;
    work_o <= w;
    ind_ptr_o <= w;
    bit_sel_o <= bs;
    to_file_o <= tf;
    @(posedge mclk_i);
    exec_o <= 1'b0;
    literal_o <= ~a;
    file_data_o <= ~a;
    #1;
  endtask : issue
endmodule : exec_core_model

// >>> alu_status_bank_select_bench.sv
// Self-checking bench for the status register bank
`timescale 1ns/100ps
module alu_status_bank_select_bench;
  import alu_status_pkg::*;
  logic        mclk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [2:0]  evs = 3'h0, bs;
  logic        pready, pslverr, irq, last_err, exec, lit_en, to_file, rvalid;
  op_e         op;
  logic [6:0]  fa;
  logic [7:0]  fd, lit, work, ptr, status, result;
  logic [8:0]  daddr, iaddr;
  logic [10:0] r;
  logic [7:0]  av [4] = '{8'h0F, 8'hFF, 8'h05, 8'h10};
  logic [7:0]  wv [4] = '{8'h01, 8'h01, 8'h06, 8'h01};
  int          error_cnt = 0, num_checks = 0, acc_cyc = 0;

  always #20 mclk_i = ~mclk_i;

  exec_core_model u_core (.mclk_i(mclk_i), .exec_o(exec), .op_o(op), .file_addr_o(fa), .file_data_o(fd),
    .use_literal_o(lit_en), .literal_o(lit), .work_o(work), .bit_sel_o(bs), .to_file_o(to_file), .ind_ptr_o(ptr));
  alu_status_bank_select u_dut (.mclk_i(mclk_i), .reset_i(reset_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .irq_o(irq), .exec_i(exec), .op_i(op), .file_addr_i(fa), .file_data_i(fd),
    .use_literal_i(lit_en), .literal_i(lit), .work_i(work), .bit_sel_i(bs), .to_file_i(to_file),
    .ind_ptr_i(ptr), .wdt_clear_i(evs[0]), .sleep_i(evs[1]), .wdt_timeout_i(evs[2]), .status_o(status),
    .result_o(result), .result_valid_o(rvalid), .direct_addr_o(daddr), .indirect_addr_o(iaddr));

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : check
  // APB transfer held until pready is sampled high; only the watchdog ends a hang
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    acc_cyc = 0;
    do begin
      @(posedge mclk_i);
      acc_cyc++;
    end while (pready !== 1'b1);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : apb
  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(nm, q, exp);
  endtask : rd
  // One-cycle event pulse {timeout, sleep, clear}
  task automatic pulse(input logic [2:0] v);
    @(posedge mclk_i);
    evs <= v;
    @(posedge mclk_i);
    evs <= 3'h0;
    #1;
  endtask : pulse
  // Reference sum: {result, zero, nibble carry, carry}
  function automatic logic [10:0] add_ref(input logic [7:0] a, input logic [7:0] b, input logic ci);
    logic [8:0] s;
    logic [4:0] h;
    s = a + b + ci;
    h = a[3:0] + b[3:0] + ci;
    return {s[7:0], s[7:0] == 8'h00, h[4], s[8]};
  endfunction : add_ref
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop
  // Sequence needs well under 1000 cycles
  initial begin
    #(40 * 3000);
    error_cnt++;
    report_and_stop();
  end

  initial begin
    repeat (20) @(posedge mclk_i);
    reset_i <= 1'b0;
    #1;
    check("reset status", status, 8'h18);
    rd("upper mirror", STATUS_ADDR_HI, 32'h18);
    pulse(3'b010);
    apb(1'b1, STATUS_ADDR_LO, 32'hFF);
    check("cause flags kept", status, 8'hF7);
    apb(1'b1, STATUS_ADDR_HI, 32'h00);
    rd("lower mirror", STATUS_ADDR_LO, 32'h10);
    pulse(3'b100);
    check("timeout", status[4:3], 2'b00);
    pulse(3'b001);
    check("wdt clear", status[4:3], 2'b11);
    for (int b = 0; b < 4; b++) begin
      apb(1'b1, STATUS_ADDR_LO, {24'h0, b[1], b[1:0], 5'h00});
      check("direct addr", daddr, {b[1:0], fa});
      check("indirect addr", iaddr, {b[1], ptr});
    end
    apb(1'b1, STATUS_ADDR_LO, 32'h00);
    // Adds and subtracts; subtract reference uses two's complement
    for (int i = 0; i < 4; i++) begin
      r = (i < 2) ? add_ref(av[i], wv[i], 1'b0) : add_ref(av[i], ~wv[i], 1'b1);
      u_core.issue((i < 2) ? OP_ADD : OP_SUB, 7'h20, 1'b1, av[i], wv[i], 3'h0, 1'b0);
      check("alu result", result, r[10:3]);
      check("result valid", rvalid, 1'b1);
      check("alu flags", status[2:0], r[2:0]);
    end
    u_core.issue(OP_RRC, 7'h20, 1'b1, 8'h02, 8'h00, 3'h0, 1'b0);
    check("rotate right", {result, status[0]}, {r[0], 7'h01, 1'b0});
    u_core.issue(OP_RLC, 7'h20, 1'b1, 8'h80, 8'h00, 3'h0, 1'b0);
    check("rotate left", {result, status[0]}, 9'h001);
    // Status is now 19h; flag writes from the data path are suppressed
    r = add_ref(8'h19, 8'h08, 1'b0);
    u_core.issue(OP_ADD, STATUS_FILE_ADDR, 1'b0, 8'h00, 8'h08, 3'h0, 1'b1);
    check("add to status", status, {r[10:8], 2'b11, r[2:0]});
    u_core.issue(OP_CLR, STATUS_FILE_ADDR, 1'b0, 8'h00, 8'h00, 3'h0, 1'b1);
    check("clear status", status, {5'b00011, 1'b1, r[1:0]});
    u_core.issue(OP_BSET, STATUS_FILE_ADDR, 1'b0, 8'h00, 8'h00, 3'h7, 1'b1);
    check("bit set", status, 8'h9E);
    u_core.issue(OP_BCLR, STATUS_FILE_ADDR, 1'b0, 8'h00, 8'h00, 3'h7, 1'b1);
    check("bit clear", status, 8'h1E);
    u_core.issue(OP_MOVW, STATUS_FILE_ADDR, 1'b0, 8'h00, 8'hE0, 3'h0, 1'b1);
    check("move to status", status, 8'hF8);
    u_core.issue(OP_SWAP, STATUS_FILE_ADDR, 1'b0, 8'h00, 8'h00, 3'h0, 1'b1);
    check("swap status", status, 8'h9F);
    // Bus write meets a core write of status: the bus must wait one cycle
    fork
      apb(1'b1, STATUS_ADDR_LO, 32'hE0);
      begin
        @(posedge mclk_i);
        u_core.issue(OP_BSET, STATUS_FILE_ADDR, 1'b0, 8'h00, 8'h00, 3'h6, 1'b1);
      end
    join
    check("stall cycles", acc_cyc, 2);
    check("core write first", result, 8'hDF);
    check("bus write after stall", status, 8'hF8);
    // Interrupt: clear, mask, raise, unmask, clear
    apb(1'b1, IRQ_STATUS_ADDR, 32'h7);
    apb(1'b1, IRQ_MASK_ADDR, 32'h0);
    pulse(3'b010);
    check("masked irq", irq, 1'b0);
    rd("irq status", IRQ_STATUS_ADDR, 32'h2);
    apb(1'b1, IRQ_MASK_ADDR, 32'h2);
    check("irq raised", irq, 1'b1);
    apb(1'b1, IRQ_STATUS_ADDR, 32'h2);
    check("irq cleared", irq, 1'b0);
    rd("unmapped", 12'h100, 32'h0);
    check("unmapped error", last_err, 1'b1);
    // Mid-run reset with all bank bits set must restore the power-on byte
    @(posedge mclk_i);
    reset_i <= 1'b1;
    @(posedge mclk_i);
    reset_i <= 1'b0;
    #1;
    check("second reset", status, 8'h18);
    check("reset result", {rvalid, result}, 9'h000);
    report_and_stop();
  end
endmodule : alu_status_bank_select_bench
